//--- logic/rheo_pkg.sv
// constants and types for the rheostat serial command unit
// ****************************************************************
// Notes on behaviour
// ****************************************************************
package rheo_pkg;
   localparam int         WORD_W       = 16;
   localparam int         DATA_W       = 10;
   localparam int         SLOT_N       = 50;
   localparam logic [9:0] MIDSCALE     = 10'h200;
   localparam logic [5:0] IDX_TOL_HI   = 6'h39;
   localparam logic [5:0] IDX_TOL_LO   = 6'h3A;
   localparam logic [5:0] IDX_LAST     = 6'h32;
   localparam int         CTL_PE_POS   = 0;
   localparam int         CTL_WE_POS   = 1;
   localparam int         CTL_OK_POS   = 3;
   localparam logic [15:0] PARK_WORD   = 16'h8001;

   typedef enum logic [3:0] {
      CMD_NOP   = 4'h0,
      CMD_WWIP  = 4'h1,
      CMD_RWIP  = 4'h2,
      CMD_STORE = 4'h3,
      CMD_RESET = 4'h4,
      CMD_RMEM  = 4'h5,
      CMD_RADDR = 4'h6,
      CMD_WCTL  = 4'h7,
      CMD_RCTL  = 4'h8,
      CMD_SHDN  = 4'h9
   } cmd_t;

   typedef struct packed {
      logic [1:0] top;
      cmd_t       cmd;
      logic [9:0] data;
   } word_t;
endpackage : rheo_pkg

//--- logic/rheo_cmd_unit.sv
// serial command interpreter of the rheostat
`timescale 1ns/100ps
module rheo_cmd_unit #(
   parameter logic [9:0] TOL_UPPER = 10'h000,
   parameter logic [9:0] TOL_LOWER = 10'h000
) (
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       sclk,
   input  wire logic       sync_n,
   input  wire logic       din,
   output logic            sdo_o,
   output logic            sdo_oe,
   output logic [9:0]      wiper_register,
   output logic            term_a_open,
   output logic            program_busy
);
   // ****************************************************************
   // link domain: shift register on serial clock
   // ****************************************************************
   logic [15:0] shift_q;
   logic        load_tgl_q;
   logic        seen_tgl_q;
   logic        first_bit;
   logic [15:0] resp_word_q;
   logic        sync_s1, sync_s2, sync_s3;
   logic [15:0] rx_word_q;
   logic [15:0] resp_q;
   logic        park_q;
   logic        out_bit_q;

   // shift in on falling edge, bits 15 first; lengths are multiples
   // of 16 so the last 16 bits remain for this device
   always_ff @(negedge sclk) begin
      if (!sync_n)
         shift_q <= {shift_q[14:0], din};
   end

   // frame start: a system side toggle not yet seen here
   assign first_bit = seen_tgl_q ^ load_tgl_q;

   always_ff @(posedge sclk) begin
      if (!sync_n)
         seen_tgl_q <= load_tgl_q;
   end

   // output changes on rising edge; response first, then the
   // received bits pass down a chain 16 clocks later
   always_ff @(posedge sclk) begin
      if (!sync_n) begin
         if (first_bit) begin
            resp_q    <= resp_word_q;
            out_bit_q <= resp_word_q[15];
         end else begin
            resp_q    <= {resp_q[14:0], shift_q[0]};
            out_bit_q <= resp_q[14];
         end
      end
   end

   // ****************************************************************
   // frame end detect in system domain
   // ****************************************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sync_s1 <= 1'b1;
         sync_s2 <= 1'b1;
         sync_s3 <= 1'b1;
      end else begin
         sync_s1 <= sync_n;
         sync_s2 <= sync_s1;
         sync_s3 <= sync_s2;
      end
   end

   logic frame_end;
   // shift_q is stable while frame select is high
   assign frame_end = sync_s2 & ~sync_s3;

   always_ff @(posedge clk_sys) begin
      if (!rstn)
         rx_word_q <= 16'h0000;
      else if (frame_end)
         rx_word_q <= shift_q;
   end

   logic  exec_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn)
         exec_q <= 1'b0;
      else
         exec_q <= frame_end;
   end

   // one toggle per executed word marks a fresh response
   always_ff @(posedge clk_sys) begin
      if (!rstn)
         load_tgl_q <= 1'b0;
      else if (exec_q)
         load_tgl_q <= ~load_tgl_q;
   end

   rheo_pkg::word_t w;
   assign w = rheo_pkg::word_t'(rx_word_q);

   // ****************************************************************
   // control register, memory and wiper
   // ****************************************************************
   logic       pe_q, we_q, ok_q, shdn_q;
   logic [9:0] wiper_q;
   logic [9:0] slot_q [1:rheo_pkg::SLOT_N];
   logic [5:0] last_q;
   logic       busy_q;
   logic [9:0] resp_data_q;
   logic        park_arm_q;

   function automatic logic [9:0] ctl_val(input logic p, input logic e,
                                          input logic k);
      ctl_val = 10'h000;
      ctl_val[rheo_pkg::CTL_PE_POS] = p;
      ctl_val[rheo_pkg::CTL_WE_POS] = e;
      ctl_val[rheo_pkg::CTL_OK_POS] = k;
   endfunction : ctl_val

   function automatic logic [9:0] restore_val(input logic [5:0] l,
                                              input logic [9:0] v);
      restore_val = (l == 6'h00) ? rheo_pkg::MIDSCALE : v;
   endfunction : restore_val

   logic [9:0] last_slot_val;
   assign last_slot_val = (last_q == 6'h00) ? rheo_pkg::MIDSCALE
                                            : slot_q[last_q];

   // control bits; shutdown cmds run in any mode
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pe_q <= 1'b0;
         we_q <= 1'b0;
      end else if (exec_q && w.cmd == rheo_pkg::CMD_WCTL) begin
         pe_q <= w.data[0];
         we_q <= w.data[1];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn)
         shdn_q <= 1'b0;
      else if (exec_q && w.cmd == rheo_pkg::CMD_SHDN)
         shdn_q <= w.data[0];
      else if (exec_q && w.cmd == rheo_pkg::CMD_RESET)
         shdn_q <= 1'b0;
   end

   // wiper untouched by shutdown
   always_ff @(posedge clk_sys) begin
      if (!rstn)
         wiper_q <= rheo_pkg::MIDSCALE;
      else if (exec_q && w.cmd == rheo_pkg::CMD_RESET)
         wiper_q <= restore_val(last_q, last_slot_val);
      else if (exec_q && w.cmd == rheo_pkg::CMD_WWIP && we_q)
         wiper_q <= w.data;
   end

   // store into next slot while enabled and not full
   logic store_go;
   assign store_go = exec_q && w.cmd == rheo_pkg::CMD_STORE && pe_q
                     && last_q < rheo_pkg::IDX_LAST;

   genvar gi;
   generate
      for (gi = 1; gi <= rheo_pkg::SLOT_N; gi++) begin : g_slot
         always_ff @(posedge clk_sys) begin
            if (!rstn)
               slot_q[gi] <= 10'h000;
            else if (store_go && last_q == 6'(gi - 1))
               slot_q[gi] <= wiper_q;
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         last_q <= 6'h00;
         ok_q   <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         busy_q <= store_go;
         if (store_go) begin
            last_q <= last_q + 6'h01;
            ok_q   <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // readback selection for next frame
   // ****************************************************************
   function automatic logic [9:0] mem_read(input logic [5:0] idx,
                                           input logic [5:0] l,
                                           input logic [9:0] v);
      if (idx == rheo_pkg::IDX_TOL_HI)
         mem_read = TOL_UPPER;
      else if (idx == rheo_pkg::IDX_TOL_LO)
         mem_read = TOL_LOWER;
      else if (idx != 6'h00 && idx <= rheo_pkg::IDX_LAST && idx <= l)
         mem_read = v;
      else
         mem_read = 10'h000;
   endfunction : mem_read

   logic [5:0] ridx;
   logic [9:0] slot_pick;
   assign ridx = w.data[5:0];
   assign slot_pick = (ridx != 6'h00 && ridx <= rheo_pkg::IDX_LAST)
                      ? slot_q[ridx] : 10'h000;

   always_ff @(posedge clk_sys) begin
      if (!rstn)
         resp_word_q <= 16'h0000;
      else if (exec_q) begin
         unique case (w.cmd)
            rheo_pkg::CMD_RWIP:
               resp_word_q <= {6'h00, wiper_q};
            rheo_pkg::CMD_RMEM:
               resp_word_q <= {6'h00, mem_read(ridx, last_q, slot_pick)};
            rheo_pkg::CMD_RADDR:
               resp_word_q <= {10'h000, last_q};
            rheo_pkg::CMD_RCTL:
               resp_word_q <= {6'h00, ctl_val(pe_q, we_q, ok_q)};
            default:
               resp_word_q <= rx_word_q;
         endcase
      end
   end

   // park request: armed by park word, done by following nop
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         park_arm_q <= 1'b0;
         park_q     <= 1'b0;
      end else if (exec_q) begin
         park_arm_q <= (rx_word_q == rheo_pkg::PARK_WORD);
         park_q     <= park_arm_q && w.cmd == rheo_pkg::CMD_NOP;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // park level taken at frame start; quiet between frames
   logic park_s2;
   always_ff @(posedge sclk) begin
      if (!sync_n && first_bit)
         park_s2 <= park_q;
   end

   // open drain: drive only low bits while not parked
   assign sdo_o  = 1'b0;
   assign sdo_oe = ~park_s2 & ~out_bit_q & ~sync_n;

   assign wiper_register = wiper_q;
   assign term_a_open    = shdn_q;
   assign program_busy   = busy_q;
endmodule : rheo_cmd_unit

//--- dv/rheo_props.sv
// assertions on the rheostat command unit ports
`timescale 1ns/100ps
module rheo_props (
   input wire logic       clk_sys,
   input wire logic       rstn,
   input wire logic       sclk,
   input wire logic       sync_n,
   input wire logic       din,
   input wire logic       sdo_o,
   input wire logic       sdo_oe,
   input wire logic [9:0] wiper_register,
   input wire logic       term_a_open,
   input wire logic       program_busy
);
   // ****************
   // port properties
   // ****************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_idle;
      sync_n [*3];
   endsequence
   AST_OPEN_DRAIN: assert property (sdo_o == 1'b0)
      else $error("serial out drives high");
   AST_IDLE_RELEASE: assert property (s_idle |-> !sdo_oe)
      else $error("serial out driven while idle");
   AST_WIPER_AT_END: assert property (!$stable(wiper_register) |-> sync_n)
      else $error("wiper moved inside a frame");
   AST_TERM_AT_END: assert property (!$stable(term_a_open) |-> sync_n)
      else $error("shutdown moved inside a frame");
   AST_BUSY_PULSE: assert property (program_busy |=> !program_busy)
      else $error("store pulse too long");
   AST_BUSY_IDLE: assert property (program_busy |-> $past(sync_n))
      else $error("store inside a frame");
   AST_SHDN_KEEP: assert property ($rose(term_a_open) |-> $stable(wiper_register))
      else $error("wiper changed on shutdown");
   AST_RESET_STATE: assert property (@(posedge clk_sys) disable iff (1'b0)
      !rstn |=> wiper_register == rheo_pkg::MIDSCALE && !term_a_open)
      else $error("wrong state after reset");
endmodule : rheo_props

//--- dv/rheo_host.sv
// host model driving serial frames
`timescale 1ns/100ps
module rheo_host (
   output logic       sclk,
   output logic       sync_n,
   output logic       din,
   input  wire logic  sdo_line
);
   initial begin
      sclk = 1'b0;
      sync_n = 1'b1;
      din = 1'b1;
   end
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      sync_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         #32 sclk = 1'b1;
         din = w[i];
         #31 r[i] = sdo_line;
         #1 sclk = 1'b0;
      end
      #32 sync_n = 1'b1;
      din = ~w[0];
      #400;
   endtask : xfer
endmodule : rheo_host

//--- dv/testbench.sv
// top level bench for the rheostat command unit
`timescale 1ns/100ps
module testbench;
   logic        clk_sys;
   logic        rstn;
   wire         sclk;
   wire         sync_n;
   wire         din;
   logic        sdo_o;
   logic        sdo_oe;
   logic [9:0]  wiper_register;
   logic        term_a_open;
   logic        program_busy;
   logic [15:0] r;
   int          n_fail;
   int          n_tests;
   wire         sdo_line = sdo_oe ? sdo_o : 1'b1;

   rheo_cmd_unit #(.TOL_UPPER(10'h00A), .TOL_LOWER(10'h0B0)) dut (
      .clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .sync_n(sync_n),
      .din(din), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
      .wiper_register(wiper_register), .term_a_open(term_a_open),
      .program_busy(program_busy));
   rheo_host host (.sclk(sclk), .sync_n(sync_n), .din(din),
      .sdo_line(sdo_line));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic chk_wip(logic [9:0] e, logic t);
      chk("wiper", {6'h00, e}, {6'h00, wiper_register});
      chk("term", {15'h0000, t}, {15'h0000, term_a_open});
   endtask : chk_wip
   task automatic tx(logic [15:0] w);
      host.xfer(w, r);
   endtask : tx
   task automatic rd(string n, logic [15:0] w, logic [15:0] m,
                     logic [15:0] e);
      tx(w);
      tx(16'h0000);
      chk(n, e, r & m);
   endtask : rd
   task automatic end_sim;
      $display("checks %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      #200000;
      n_fail++;
      end_sim();
   end

   initial begin
      n_fail = 0;
      n_tests = 0;
      rstn = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1 rstn = 1'b1;
      tx(16'h0000);
      tx(16'h0500);
      chk_wip(10'h200, 1'b0);
      tx(16'h0C00);
      tx(16'h1000);
      chk_wip(10'h200, 1'b0);
      rd("wiper", 16'h0800, 16'h03FF, 16'h0200);
      $display("test protect done");
      tx(16'h1C03);
      rd("ctl", 16'h2000, 16'h000F, 16'h0003);
      tx(16'h0500);
      chk_wip(10'h100, 1'b0);
      tx(16'h0C00);
      rd("ctl", 16'h2000, 16'h000F, 16'h000B);
      tx(16'h0555);
      rd("last", 16'h1800, 16'h003F, 16'h0001);
      rd("slot", 16'h1401, 16'h03FF, 16'h0100);
      rd("tol", 16'h1439, 16'h03FF, 16'h000A);
      rd("tol", 16'h143A, 16'h03FF, 16'h00B0);
      $display("test memory done");
      tx(16'h2401);
      chk_wip(10'h155, 1'b1);
      tx(16'h0444);
      chk_wip(10'h044, 1'b1);
      tx(16'h1000);
      chk_wip(10'h100, 1'b0);
      tx(16'h2401);
      tx(16'h2400);
      chk_wip(10'h100, 1'b0);
      $display("test shutdown done");
      tx(16'h8001);
      rd("park", 16'h0000, 16'hFFFF, 16'hFFFF);
      $display("test park done");
      end_sim();
   end
endmodule : testbench

bind rheo_cmd_unit rheo_props chk_i (
   .clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .sync_n(sync_n),
   .din(din), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
   .wiper_register(wiper_register), .term_a_open(term_a_open),
   .program_busy(program_busy));
